// ===== mbcs_pkg.sv
// package of constants and types for the bypass contactor sequencer
package mbcs_pkg;
  localparam logic [1:0] MODE_SYNC_OVERLAP = 2'h1;
  localparam logic [1:0] MODE_SYNC_NO_OVERLAP = 2'h2;
  localparam logic [1:0] MODE_UNSYNC = 2'h3;
  localparam int CLK_HZ = 20000000;
  localparam int EXCITE_TIME_US_DEFAULT = 1000;
  localparam int EXCITE_CYCLES_DEFAULT = (EXCITE_TIME_US_DEFAULT * (CLK_HZ / 1000000));
  localparam int EXCITE_CNT_W = 24;
  // phase setpoint in units of 0.1 degree, signed
  localparam logic signed [11:0] PHASE_SET_MIN = -12'sd1800;
  localparam logic signed [11:0] PHASE_SET_MAX = 12'sd1799;
  localparam logic signed [11:0] PHASE_ADV_MAX = 12'sd200;
  localparam logic [11:0] ANGLE_LIMIT_MAX = 12'h0c8;
  typedef enum logic [3:0]
  {
    ST_CONV = 4'h0,
    ST_TL_SYNC = 4'h1,
    ST_TL_LINE_FB = 4'h2,
    ST_TL_CONV_OPEN = 4'h3,
    ST_TL_EXCITE = 4'h4,
    ST_LINE = 4'h5,
    ST_RT_SYNC = 4'h6,
    ST_RT_CONV_FB = 4'h7,
    ST_RT_LINE_OPEN = 4'h8,
    ST_RT_EXCITE = 4'h9,
    ST_RT_CONV_CLOSE = 4'ha
  } mbcs_state_t;
endpackage : mbcs_pkg

// ===== mbcs_sync_if.sv
// interface carrying synchronizer settings and lock result
`timescale 1ns/1ps
interface mbcs_sync_if;
  logic signed [11:0] phase_setpoint;
  logic [11:0] max_angle;
  logic [11:0] angle_diff;
  logic lock_raw;
  logic sync_ok;
  logic signed [11:0] phase_used;
  modport ctl (output phase_setpoint, output max_angle, output angle_diff, output lock_raw,
    input sync_ok, input phase_used);
  modport chk (input phase_setpoint, input max_angle, input angle_diff, input lock_raw,
    output sync_ok, output phase_used);
endinterface : mbcs_sync_if

// ===== mbcs_sync_gate.sv
// clamps phase setpoint and angle limit, qualifies synchronizer lock
`timescale 1ns/1ps
module mbcs_sync_gate
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  mbcs_sync_if.chk sif
);
  import mbcs_pkg::*;
  logic sync_ok_reg;
  logic sync_ok_next;
  logic signed [11:0] phase_reg;
  logic signed [11:0] phase_next;
  logic [11:0] lim;

  function automatic logic signed [11:0] clamp_s(input logic signed [11:0] v,
    input logic signed [11:0] lo, input logic signed [11:0] hi);
    clamp_s = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp_s

  always_comb
  begin
    lim = (sif.max_angle > ANGLE_LIMIT_MAX) ? ANGLE_LIMIT_MAX : sif.max_angle;
    sync_ok_next = sif.lock_raw && (sif.angle_diff <= lim);
    phase_next = clamp_s(sif.phase_setpoint, PHASE_SET_MIN, PHASE_SET_MAX);
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      sync_ok_reg <= 1'b0;
      phase_reg <= 12'sh000;
    end
    else
    begin
      sync_ok_reg <= sync_ok_next;
      phase_reg <= phase_next;
    end
  end

  assign sif.sync_ok = sync_ok_reg;
  assign sif.phase_used = phase_reg;
endmodule : mbcs_sync_gate

// ===== mbcs_seq.sv
// bypass contactor sequencer top
`timescale 1ns/1ps
module mbcs_seq
#(
  parameter int EXCITE_CYCLES = mbcs_pkg::EXCITE_CYCLES_DEFAULT
)
(
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic [1:0] I_BYPASS_MODE_SELECT,
  input wire logic I_BYPASS_COMMAND,
  input wire logic I_ON_COMMAND,
  input wire logic I_CONVERTER_CONTACTOR_FEEDBACK,
  input wire logic I_LINE_CONTACTOR_FEEDBACK,
  input wire logic I_SYNC_LOCK_REACHED,
  input wire logic [11:0] I_ANGLE_DIFFERENCE,
  input wire logic signed [11:0] I_PHASE_ADVANCE_SETPOINT,
  input wire logic [11:0] I_MAX_ANGLE_DIFFERENCE,
  output logic O_CONVERTER_CONTACTOR_CMD,
  output logic O_LINE_CONTACTOR_CMD,
  output logic O_SYNC_REQUEST,
  output logic O_PULSE_ENABLE,
  output logic O_HOT_STANDBY,
  output logic O_BASIC_STANDBY,
  output logic O_LINE_OPERATION,
  output logic signed [11:0] O_PHASE_SETPOINT
);
  import mbcs_pkg::*;

  // three-stage synchronisers for pins
  logic [2:0] byp_sr;
  logic [2:0] on_sr;
  logic [2:0] cfb_sr;
  logic [2:0] lfb_sr;
  logic [2:0] lock_sr;
  logic byp_q;
  logic on_q;
  logic cfb_q;
  logic lfb_q;
  logic lock_q;

  mbcs_state_t state_reg;
  mbcs_state_t state_next;
  logic conv_cmd_reg;
  logic conv_cmd_next;
  logic line_cmd_reg;
  logic line_cmd_next;
  logic sync_req_reg;
  logic sync_req_next;
  logic pulse_reg;
  logic pulse_next;
  logic hot_reg;
  logic hot_next;
  logic basic_reg;
  logic basic_next;
  logic byp_prev_reg;
  logic line_op_reg;
  logic line_op_next;
  logic [EXCITE_CNT_W-1:0] cnt_reg;
  logic [EXCITE_CNT_W-1:0] cnt_next;
  logic [1:0] mode_reg;
  logic [1:0] mode_next;
  logic byp_rise;
  logic byp_fall;
  logic lock_ok;
  logic synced_mode;

  mbcs_sync_if sif ();

  function automatic logic agree(input logic [2:0] sr, input logic held);
    agree = (sr[2] == sr[1]) ? sr[2] : held;
  endfunction : agree

  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      byp_sr <= 3'h0;
      on_sr <= 3'h0;
      cfb_sr <= 3'h0;
      lfb_sr <= 3'h0;
      lock_sr <= 3'h0;
      byp_q <= 1'b0;
      on_q <= 1'b0;
      cfb_q <= 1'b0;
      lfb_q <= 1'b0;
      lock_q <= 1'b0;
    end
    else
    begin
      byp_sr <= {byp_sr[1:0], I_BYPASS_COMMAND};
      on_sr <= {on_sr[1:0], I_ON_COMMAND};
      cfb_sr <= {cfb_sr[1:0], I_CONVERTER_CONTACTOR_FEEDBACK};
      lfb_sr <= {lfb_sr[1:0], I_LINE_CONTACTOR_FEEDBACK};
      lock_sr <= {lock_sr[1:0], I_SYNC_LOCK_REACHED};
      byp_q <= agree(byp_sr, byp_q);
      on_q <= agree(on_sr, on_q);
      cfb_q <= agree(cfb_sr, cfb_q);
      lfb_q <= agree(lfb_sr, lfb_q);
      lock_q <= agree(lock_sr, lock_q);
    end
  end

  assign sif.phase_setpoint = I_PHASE_ADVANCE_SETPOINT;
  assign sif.max_angle = I_MAX_ANGLE_DIFFERENCE;
  assign sif.angle_diff = I_ANGLE_DIFFERENCE;
  assign sif.lock_raw = lock_q;

  mbcs_sync_gate u_gate
  (
    .i_clk(I_CLK),
    .i_rst_b(I_RST_B),
    .sif(sif.chk)
  );

  always_comb
  begin
    byp_rise = byp_q && !byp_prev_reg;
    byp_fall = !byp_q && byp_prev_reg;
    lock_ok = sif.sync_ok;
    synced_mode = (mode_reg == MODE_SYNC_OVERLAP) || (mode_reg == MODE_SYNC_NO_OVERLAP);
    state_next = state_reg;
    conv_cmd_next = conv_cmd_reg;
    line_cmd_next = line_cmd_reg;
    sync_req_next = sync_req_reg;
    pulse_next = pulse_reg;
    hot_next = hot_reg;
    basic_next = basic_reg;
    mode_next = mode_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      ST_CONV:
      begin
        mode_next = I_BYPASS_MODE_SELECT;
        conv_cmd_next = 1'b1;
        line_cmd_next = 1'b0;
        pulse_next = 1'b1;
        hot_next = 1'b0;
        basic_next = 1'b0;
        if (byp_rise && cfb_q && !lfb_q && I_BYPASS_MODE_SELECT != 2'h0)
        begin
          if (I_BYPASS_MODE_SELECT == MODE_UNSYNC)
          begin
            pulse_next = 1'b0;
            conv_cmd_next = 1'b0;
            state_next = ST_TL_CONV_OPEN;
          end
          else
          begin
            sync_req_next = 1'b1;
            state_next = ST_TL_SYNC;
          end
        end
      end
      ST_TL_SYNC:
      begin
        if (lock_ok)
        begin
          if (mode_reg == MODE_SYNC_OVERLAP)
          begin
            line_cmd_next = 1'b1;
            state_next = ST_TL_LINE_FB;
          end
          else
          begin
            conv_cmd_next = 1'b0;
            pulse_next = 1'b0;
            state_next = ST_TL_CONV_OPEN;
          end
        end
      end
      ST_TL_CONV_OPEN:
      begin
        if (!cfb_q)
        begin
          cnt_next = '0;
          state_next = synced_mode ? ST_TL_LINE_FB : ST_TL_EXCITE;
          line_cmd_next = synced_mode;
        end
      end
      ST_TL_EXCITE:
      begin
        if (cnt_reg >= EXCITE_CNT_W'(EXCITE_CYCLES - 1))
        begin
          line_cmd_next = 1'b1;
          state_next = ST_TL_LINE_FB;
        end
        else
          cnt_next = cnt_reg + 1'b1;
      end
      ST_TL_LINE_FB:
      begin
        if (lfb_q)
        begin
          conv_cmd_next = 1'b0;
          pulse_next = 1'b0;
          sync_req_next = 1'b0;
          hot_next = 1'b1;
          state_next = ST_LINE;
        end
      end
      ST_LINE:
      begin
        if (hot_reg && !on_q)
        begin
          hot_next = 1'b0;
          basic_next = 1'b1;
        end
        if (byp_fall)
        begin
          hot_next = 1'b0;
          basic_next = 1'b0;
          if (mode_reg == MODE_UNSYNC)
          begin
            line_cmd_next = 1'b0;
            state_next = ST_RT_LINE_OPEN;
          end
          else
          begin
            sync_req_next = 1'b1;
            state_next = ST_RT_SYNC;
          end
        end
      end
      ST_RT_SYNC:
      begin
        pulse_next = 1'b1;
        if (pulse_reg && lock_ok)
        begin
          conv_cmd_next = 1'b1;
          state_next = ST_RT_CONV_FB;
        end
      end
      ST_RT_CONV_FB:
      begin
        if (cfb_q)
        begin
          line_cmd_next = 1'b0;
          sync_req_next = 1'b0;
          state_next = ST_CONV;
        end
      end
      ST_RT_LINE_OPEN:
      begin
        if (!lfb_q)
        begin
          cnt_next = '0;
          state_next = ST_RT_EXCITE;
        end
      end
      ST_RT_EXCITE:
      begin
        if (cnt_reg >= EXCITE_CNT_W'(EXCITE_CYCLES - 1))
        begin
          conv_cmd_next = 1'b1;
          state_next = ST_RT_CONV_CLOSE;
        end
        else
          cnt_next = cnt_reg + 1'b1;
      end
      ST_RT_CONV_CLOSE:
      begin
        if (cfb_q)
        begin
          pulse_next = 1'b1;
          state_next = ST_CONV;
        end
      end
      default:
        state_next = ST_CONV;
    endcase
    line_op_next = (state_next == ST_LINE);
  end

  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      state_reg <= ST_CONV;
      conv_cmd_reg <= 1'b1;
      line_cmd_reg <= 1'b0;
      sync_req_reg <= 1'b0;
      pulse_reg <= 1'b1;
      hot_reg <= 1'b0;
      basic_reg <= 1'b0;
      mode_reg <= 2'h0;
      cnt_reg <= '0;
      byp_prev_reg <= 1'b0;
      line_op_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      conv_cmd_reg <= conv_cmd_next;
      line_cmd_reg <= line_cmd_next;
      sync_req_reg <= sync_req_next;
      pulse_reg <= pulse_next;
      hot_reg <= hot_next;
      basic_reg <= basic_next;
      mode_reg <= mode_next;
      cnt_reg <= cnt_next;
      byp_prev_reg <= byp_q;
      line_op_reg <= line_op_next;
    end
  end

  always_comb
  begin
    O_CONVERTER_CONTACTOR_CMD = conv_cmd_reg;
    O_LINE_CONTACTOR_CMD = line_cmd_reg;
    O_SYNC_REQUEST = sync_req_reg;
    O_PULSE_ENABLE = pulse_reg;
    O_HOT_STANDBY = hot_reg;
    O_BASIC_STANDBY = basic_reg;
    O_LINE_OPERATION = line_op_reg;
    O_PHASE_SETPOINT = sif.phase_used;
  end
endmodule : mbcs_seq

// ===== mbcs_seq_properties.sv
// port checks for the bypass contactor sequencer
`timescale 1ns/1ps
module mbcs_seq_properties
  import mbcs_pkg::*;
#(
  parameter int EXCITE_CYCLES = 8
)
(
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic [1:0] I_BYPASS_MODE_SELECT,
  input wire logic I_CONVERTER_CONTACTOR_FEEDBACK,
  input wire logic I_LINE_CONTACTOR_FEEDBACK,
  input wire logic I_SYNC_LOCK_REACHED,
  input wire logic O_CONVERTER_CONTACTOR_CMD,
  input wire logic O_LINE_CONTACTOR_CMD,
  input wire logic O_SYNC_REQUEST,
  input wire logic O_PULSE_ENABLE,
  input wire logic O_HOT_STANDBY,
  input wire logic O_BASIC_STANDBY
);
  wire logic cc = O_CONVERTER_CONTACTOR_CMD;
  wire logic lc = O_LINE_CONTACTOR_CMD;
  wire logic sr = O_SYNC_REQUEST;
  wire logic pe = O_PULSE_ENABLE;
  wire logic hs = O_HOT_STANDBY;
  wire logic [1:0] md = I_BYPASS_MODE_SELECT;
  wire logic cfb = I_CONVERTER_CONTACTOR_FEEDBACK;
  wire logic lfb = I_LINE_CONTACTOR_FEEDBACK;
  logic [15:0] open_cnt_reg;
  logic [15:0] open_cnt_next;
  // cycles with both contactors reported open
  always_comb
  begin
    open_cnt_next = 16'h0;
    if (!cfb && !lfb)
      open_cnt_next = (open_cnt_reg == 16'hffff) ? open_cnt_reg : open_cnt_reg + 16'h1;
  end
  always_ff @(posedge I_CLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
      open_cnt_reg <= 16'h0;
    else
      open_cnt_reg <= open_cnt_next;
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);
  sequence s_sync_first;
    sr && !pe ##1 pe;
  endsequence
  property p_reset_state;
    $rose(I_RST_B) |-> cc && !lc && !sr;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
  property p_sync_req;
    $rose(sr) && !lc |-> cc && (md == MODE_SYNC_OVERLAP || md == MODE_SYNC_NO_OVERLAP);
  endproperty
  a_sync_req: assert property (p_sync_req) else $error("sync request out of place");
  property p_line_lock;
    $rose(lc) && md != MODE_UNSYNC |-> $past(I_SYNC_LOCK_REACHED, 4);
  endproperty
  a_line_lock: assert property (p_line_lock) else $error("line closed without lock");
  property p_hot;
    $rose(hs) |-> lc && !cc && !pe && $past(lfb, 4);
  endproperty
  a_hot: assert property (p_hot) else $error("hot standby entered wrongly");
  property p_basic;
    $rose(O_BASIC_STANDBY) |-> $past(hs) && !hs;
  endproperty
  a_basic: assert property (p_basic) else $error("basic standby entered wrongly");
  property p_retrieve;
    $rose(sr) && lc |-> s_sync_first;
  endproperty
  a_retrieve: assert property (p_retrieve) else $error("pulses before sync request");
  property p_line_release;
    $fell(lc) && md != MODE_UNSYNC |-> cc && $past(cfb, 4);
  endproperty
  a_line_release: assert property (p_line_release) else $error("line opened early");
  property p_no_overlap;
    $rose(lc) && md == MODE_SYNC_NO_OVERLAP |-> !cc && !$past(cfb, 4);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("contactors overlap");
  property p_interlock;
    md == MODE_UNSYNC |-> !(cc && lc) && !(cfb && lfb);
  endproperty
  a_interlock: assert property (p_interlock) else $error("interlock broken");
  property p_excite;
    ($rose(lc) || $rose(cc)) && md == MODE_UNSYNC |-> open_cnt_reg >= EXCITE_CYCLES;
  endproperty
  a_excite: assert property (p_excite) else $error("excitation wait too short");
endmodule : mbcs_seq_properties
bind mbcs_seq mbcs_seq_properties #(.EXCITE_CYCLES(EXCITE_CYCLES)) u_props
(
  .I_CLK, .I_RST_B, .I_BYPASS_MODE_SELECT, .I_CONVERTER_CONTACTOR_FEEDBACK,
  .I_LINE_CONTACTOR_FEEDBACK, .I_SYNC_LOCK_REACHED, .O_CONVERTER_CONTACTOR_CMD,
  .O_LINE_CONTACTOR_CMD, .O_SYNC_REQUEST, .O_PULSE_ENABLE, .O_HOT_STANDBY, .O_BASIC_STANDBY
);

// ===== mbcs_contactor_model.sv
// contactor pair model: feedback follows command after a pickup delay
`timescale 1ns/1ps
module mbcs_contactor_model
#(
  parameter int DLY = 3
)
(
  input wire logic i_clk,
  input wire logic i_conv_cmd,
  input wire logic i_line_cmd,
  output logic o_conv_fb,
  output logic o_line_fb
);
  logic [DLY-1:0] conv_sh = '0;
  logic [DLY-1:0] line_sh = '0;
  // command 1 closes, 0 opens
  always @(posedge i_clk)
  begin
    conv_sh <= {conv_sh[DLY-2:0], i_conv_cmd};
    line_sh <= {line_sh[DLY-2:0], i_line_cmd};
  end
  assign o_conv_fb = conv_sh[DLY-1];
  assign o_line_fb = line_sh[DLY-1];
endmodule : mbcs_contactor_model

// ===== mbcs_seq_tb.sv
// self-checking bench for the bypass contactor sequencer
`timescale 1ns/1ps
module mbcs_seq_tb;
  import mbcs_pkg::*;
  logic I_CLK = 1'b0;
  logic I_RST_B = 1'b0;
  logic [1:0] mode = 2'h0;
  logic byp = 1'b0;
  logic on_cmd = 1'b1;
  logic lock = 1'b0;
  logic [11:0] ang = 12'h000;
  logic [11:0] ph = 12'h000;
  logic [11:0] lim = 12'h12c;
  logic cfb, lfb, ccmd, lcmd, sreq, pen, hot, basic, lop;
  logic [11:0] ph_o;
  int failures = 0;
  int compares = 0;
  wire logic [6:0] obs = {ccmd, lcmd, sreq, pen, hot, basic, lop};
  always #25 I_CLK = ~I_CLK;
  mbcs_seq #(.EXCITE_CYCLES(8)) u_dut
  (
    .I_CLK(I_CLK),
    .I_RST_B(I_RST_B),
    .I_BYPASS_MODE_SELECT(mode),
    .I_BYPASS_COMMAND(byp),
    .I_ON_COMMAND(on_cmd),
    .I_CONVERTER_CONTACTOR_FEEDBACK(cfb),
    .I_LINE_CONTACTOR_FEEDBACK(lfb),
    .I_SYNC_LOCK_REACHED(lock),
    .I_ANGLE_DIFFERENCE(ang),
    .I_PHASE_ADVANCE_SETPOINT(ph),
    .I_MAX_ANGLE_DIFFERENCE(lim),
    .O_CONVERTER_CONTACTOR_CMD(ccmd),
    .O_LINE_CONTACTOR_CMD(lcmd),
    .O_SYNC_REQUEST(sreq),
    .O_PULSE_ENABLE(pen),
    .O_HOT_STANDBY(hot),
    .O_BASIC_STANDBY(basic),
    .O_LINE_OPERATION(lop),
    .O_PHASE_SETPOINT(ph_o)
  );
  mbcs_contactor_model u_plant
  (
    .i_clk(I_CLK),
    .i_conv_cmd(ccmd),
    .i_line_cmd(lcmd),
    .o_conv_fb(cfb),
    .o_line_fb(lfb)
  );
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(posedge I_CLK);
    #1;
  endtask : idle
  // bounded wait for one observed output to reach a level
  task automatic wait_bit(input int b, input logic v);
    int n;
    n = 0;
    while (obs[b] !== v && n < 300)
    begin
      idle(1);
      n++;
    end
    check(12'(obs[b]), 12'(v));
  endtask : wait_bit
  task automatic give_verdict();
    $display("TB: failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic sync_run(input logic [1:0] m);
    @(posedge I_CLK);
    mode <= m;
    byp <= 1'b1;
    ang <= 12'h0c9;
    wait_bit(4, 1'b1);
    @(posedge I_CLK);
    lock <= 1'b1;
    idle(20);
    check(12'(obs[6:5]), 12'h002);
    @(posedge I_CLK);
    ang <= 12'h0c8;
    wait_bit(2, 1'b1);
    check(12'(obs[6:3]), 12'h004);
    check(12'(obs[0]), 12'h001);
    @(posedge I_CLK);
    lock <= 1'b0;
    byp <= 1'b0;
    wait_bit(4, 1'b1);
    wait_bit(3, 1'b1);
    @(posedge I_CLK);
    lock <= 1'b1;
    wait_bit(6, 1'b1);
    wait_bit(5, 1'b0);
    check(12'(obs[6:4]), 12'h004);
    @(posedge I_CLK);
    lock <= 1'b0;
    idle(12);
  endtask : sync_run
  initial
  begin
    idle(6);
    check(12'(obs), 12'h048);
    @(posedge I_CLK);
    I_RST_B <= 1'b1;
    idle(12);
    @(posedge I_CLK);
    ph <= 12'h7ff;
    idle(3);
    check(ph_o, 12'h707);
    @(posedge I_CLK);
    ph <= 12'h800;
    idle(3);
    check(ph_o, 12'h8f8);
    @(posedge I_CLK);
    ph <= 12'h0c8;
    idle(3);
    check(ph_o, 12'h0c8);
    @(posedge I_CLK);
    byp <= 1'b1;
    idle(20);
    check(12'(obs), 12'h048);
    @(posedge I_CLK);
    byp <= 1'b0;
    idle(8);
    sync_run(MODE_SYNC_OVERLAP);
    sync_run(MODE_SYNC_NO_OVERLAP);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge I_CLK);
      mode <= MODE_UNSYNC;
      byp <= 1'b1;
      wait_bit(6, 1'b0);
      check(12'(obs[3]), 12'h000);
      wait_bit(2, 1'b1);
      check(12'(obs[4]), 12'h000);
      if (k == 1)
        break;
      @(posedge I_CLK);
      byp <= 1'b0;
      wait_bit(5, 1'b0);
      wait_bit(3, 1'b1);
      check(12'(obs[6]), 12'h001);
    end
    @(posedge I_CLK);
    on_cmd <= 1'b0;
    wait_bit(1, 1'b1);
    check(12'(obs[2]), 12'h000);
    give_verdict();
  end
  initial
  begin
    #500000;
    failures++;
    give_verdict();
  end
endmodule : mbcs_seq_tb
